// *** bench/buck_sense_model.sv ***
// Oscillator and peak current comparator model for the buck controller.
`timescale 1ns/100ps
module buck_sense_model #(
  parameter int PERIOD = 16,
  parameter int RAMP = 6
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic hs_gate,
  output logic cycle_start,
  output logic peak_trip
);
  int osc_cnt;
  int ramp_cnt;
  // Current ramps while the high side conducts and trips after RAMP clocks.
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      osc_cnt <= 0;
      ramp_cnt <= 0;
      cycle_start <= 1'b0;
      peak_trip <= 1'b0;
    end
    else
    begin
      osc_cnt <= (osc_cnt == PERIOD - 1) ? 0 : osc_cnt + 1;
      cycle_start <= (osc_cnt == PERIOD - 1);
      ramp_cnt <= hs_gate ? ramp_cnt + 1 : 0;
      peak_trip <= hs_gate && (ramp_cnt >= RAMP - 1);
    end
  end
endmodule // buck_sense_model

// *** bench/buck_switch_protection_control_tb.sv ***
// Self-checking bench for the buck switch protection controller.
`timescale 1ns/100ps
module buck_switch_protection_control_tb;
  localparam int OVW = 8;
  localparam int OVH = 16;
  localparam int THH = 32;
  logic clk = 1'b0, nrst = 1'b0, enable_in = 1'b0, undervoltage_lockout = 1'b0;
  logic softstart_above_fb = 1'b0, boot_below_vin = 1'b0, boot_below_reg = 1'b0, boot_uv = 1'b0;
  logic output_overvoltage_guard = 1'b0, ls_source_limit = 1'b0, ls_sink_limit = 1'b0;
  logic overload = 1'b0, light_load = 1'b0, thermal_hot = 1'b0, thermal_cool = 1'b0;
  logic cycle_start, peak_trip, hs_gate, ls_gate, boot_charge_en, softstart_reset, hiccup_active;
  int error_cnt = 0;
  int n_compared = 0;
  always #5 clk = ~clk;
  buck_sense_model i_sense (.clk, .nrst, .hs_gate, .cycle_start, .peak_trip);
  buck_switch_protection_control #(.OVL_WAIT(OVW), .OVL_HICCUP(OVH), .THERM_HICCUP(THH)) i_dut (
    .clk, .nrst, .cycle_start, .enable_in, .undervoltage_lockout, .softstart_above_fb,
    .boot_below_vin, .boot_below_reg, .boot_uv, .output_overvoltage_guard, .peak_trip,
    .ls_source_limit, .ls_sink_limit, .overload, .light_load, .thermal_hot, .thermal_cool,
    .hs_gate, .ls_gate, .boot_charge_en, .softstart_reset, .hiccup_active);
  task tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task chk(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task gates(input logic h, input logic l);
    chk("hs_gate", h, hs_gate);
    chk("ls_gate", l, ls_gate);
  endtask
  task to_cs();
    for (int i = 0; i < 40 && cycle_start !== 1'b1; i++) tick(1);
    chk("cycle_start", 1'b1, cycle_start);
    tick(1);
  endtask
  task cs_n(input int n);
    repeat (n) to_cs();
  endtask
  task results();
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task t_start();
    chk("softstart_reset", 1'b1, softstart_reset);
    enable_in = 1'b1;
    cs_n(2);
    gates(0, 0);
    softstart_above_fb = 1'b1;
    tick(2);
    to_cs();
    gates(1, 0);
  endtask
  task t_boot();
    for (int i = 0; i < 4; i++)
    begin
      boot_below_vin = i[0];
      boot_below_reg = i[1];
      tick(2);
      chk("boot_charge_en", logic'(i == 3), boot_charge_en);
    end
  endtask
  task t_trip();
    to_cs();
    tick(7);
    gates(0, 1);
    to_cs();
    boot_uv = 1'b1;
    tick(2);
    gates(0, 1);
    boot_uv = 1'b0;
  endtask
  task t_ov();
    to_cs();
    output_overvoltage_guard = 1'b1;
    tick(2);
    chk("hs_gate", 1'b0, hs_gate);
    to_cs();
    chk("hs_gate", 1'b0, hs_gate);
    output_overvoltage_guard = 1'b0;
    tick(2);
    chk("hs_gate", 1'b0, hs_gate);
    to_cs();
    chk("hs_gate", 1'b1, hs_gate);
    light_load = 1'b1;
    to_cs();
    chk("hs_gate", 1'b0, hs_gate);
    light_load = 1'b0;
    to_cs();
    chk("hs_gate", 1'b1, hs_gate);
  endtask
  task t_src();
    ls_source_limit = 1'b1;
    tick(1);
    ls_source_limit = 1'b0;
    to_cs();
    gates(1, 0);
    ls_source_limit = 1'b1;
    cs_n(2);
    gates(0, 1);
    ls_source_limit = 1'b0;
    to_cs();
    gates(1, 0);
  endtask
  task t_sink();
    to_cs();
    tick(7);
    ls_sink_limit = 1'b1;
    tick(2);
    gates(0, 0);
    ls_sink_limit = 1'b0;
    tick(2);
    gates(0, 0);
    to_cs();
    gates(1, 0);
  endtask
  task t_ovl();
    overload = 1'b1;
    cs_n(5);
    overload = 1'b0;
    to_cs();
    overload = 1'b1;
    cs_n(OVW);
    chk("hiccup_active", 1'b0, hiccup_active);
    to_cs();
    tick(1);
    chk("hiccup_active", 1'b1, hiccup_active);
    gates(0, 0);
    overload = 1'b0;
    softstart_above_fb = 1'b0;
    cs_n(OVH - 1);
    chk("hiccup_active", 1'b1, hiccup_active);
    chk("softstart_reset", 1'b1, softstart_reset);
    to_cs();
    chk("hiccup_active", 1'b0, hiccup_active);
    to_cs();
    gates(0, 0);
    softstart_above_fb = 1'b1;
    cs_n(2);
    gates(1, 0);
  endtask
  task t_therm();
    to_cs();
    thermal_hot = 1'b1;
    tick(2);
    gates(0, 0);
    thermal_hot = 1'b0;
    cs_n(THH + 4);
    gates(0, 0);
    thermal_cool = 1'b1;
    cs_n(THH - 1);
    chk("hiccup_active", 1'b1, hiccup_active);
    to_cs();
    chk("hiccup_active", 1'b0, hiccup_active);
    cs_n(3);
    thermal_cool = 1'b0;
    to_cs();
    gates(1, 0);
  endtask
  task t_dis();
    for (int i = 0; i < 2; i++)
    begin
      to_cs();
      enable_in = (i == 1);
      undervoltage_lockout = (i == 1);
      tick(2);
      gates(0, 0);
      chk("softstart_reset", 1'b1, softstart_reset);
      enable_in = 1'b1;
      undervoltage_lockout = 1'b0;
      cs_n(2);
      to_cs();
      gates(1, 0);
    end
  endtask
  always @(negedge clk)
    if (hs_gate === 1'b1 && ls_gate === 1'b1)
    begin
      error_cnt++;
      $display("Error gate overlap expected 0 seen 1");
    end
  initial
  begin
    #200000;
    error_cnt++;
    results();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    #2 nrst = 1'b1;
    tick(1);
    t_start();
    t_boot();
    t_trip();
    t_ov();
    t_src();
    t_sink();
    t_ovl();
    t_therm();
    t_dis();
    results();
  end
endmodule // buck_switch_protection_control_tb

// *** core/buck_ctrl_pkg.sv ***
// Constants and state type for the buck switch protection controller.
package buck_ctrl_pkg;
  localparam int unsigned OVERLOAD_WAIT_CYCLES = 512;
  localparam int unsigned OVERLOAD_HICCUP_CYCLES = 16384;
  localparam int unsigned THERMAL_HICCUP_CYCLES = 32768;
  localparam int unsigned HICCUP_CNT_W = 16;
  localparam logic [HICCUP_CNT_W-1:0] HICCUP_CNT_RST = 16'h0000;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PREBIAS,
    ST_RUN,
    ST_OVL_HICCUP,
    ST_THERM_HOT,
    ST_THERM_COOL
  } ctrl_state_t;
endpackage

// *** core/buck_switch_protection_control.sv ***
// Gate command and protection sequencer for a synchronous step-down converter.
`timescale 1ns/100ps
module buck_switch_protection_control
  import buck_ctrl_pkg::*;
#(
  parameter int unsigned OVL_WAIT = OVERLOAD_WAIT_CYCLES,
  parameter int unsigned OVL_HICCUP = OVERLOAD_HICCUP_CYCLES,
  parameter int unsigned THERM_HICCUP = THERMAL_HICCUP_CYCLES
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cycle_start,
  input wire logic enable_in,
  input wire logic undervoltage_lockout,
  input wire logic softstart_above_fb,
  input wire logic boot_below_vin,
  input wire logic boot_below_reg,
  input wire logic boot_uv,
  input wire logic output_overvoltage_guard,
  input wire logic peak_trip,
  input wire logic ls_source_limit,
  input wire logic ls_sink_limit,
  input wire logic overload,
  input wire logic light_load,
  input wire logic thermal_hot,
  input wire logic thermal_cool,
  output logic hs_gate,
  output logic ls_gate,
  output logic boot_charge_en,
  output logic softstart_reset,
  output logic hiccup_active
);
  ctrl_state_t state_q, state_d;
  logic [HICCUP_CNT_W-1:0] cnt_q, cnt_d;
  logic hs_q, hs_d, ls_q, ls_d, bc_q, bc_d, ssr_q, ssr_d, hic_q, hic_d;
  logic ov_mask_q, ov_mask_d, sink_off_q, sink_off_d;
  logic [HICCUP_CNT_W-1:0] ovl_lim, ovl_hic_lim, th_lim;

  assign ovl_lim = HICCUP_CNT_W'(OVL_WAIT);
  assign ovl_hic_lim = HICCUP_CNT_W'(OVL_HICCUP - 1);
  assign th_lim = HICCUP_CNT_W'(THERM_HICCUP - 1);
  assign hs_gate = hs_q;
  assign ls_gate = ls_q;
  assign boot_charge_en = bc_q;
  assign softstart_reset = ssr_q;
  assign hiccup_active = hic_q;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    hs_d = hs_q;
    ls_d = ls_q;
    ov_mask_d = ov_mask_q;
    sink_off_d = sink_off_q;
    // soft-start held in reset outside prebias and run
    ssr_d = (state_q != ST_RUN) && (state_q != ST_PREBIAS);
    bc_d = boot_below_vin && boot_below_reg;
    unique case (state_q)
      ST_IDLE:
      begin
        cnt_d = HICCUP_CNT_RST;
        if (enable_in && !undervoltage_lockout)
        begin
          state_d = ST_PREBIAS;
        end
      end
      ST_PREBIAS:
      begin
        hs_d = 1'b0;
        ls_d = 1'b0;
        ov_mask_d = 1'b0;
        sink_off_d = 1'b0;
        cnt_d = HICCUP_CNT_RST;
        if (softstart_above_fb)
        begin
          state_d = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (output_overvoltage_guard)
        begin
          ov_mask_d = 1'b1;
        end
        if (cycle_start)
        begin
          sink_off_d = 1'b0;
          ov_mask_d = output_overvoltage_guard;
          if (!ls_source_limit && !output_overvoltage_guard && !light_load && !boot_uv)
          begin
            hs_d = 1'b1;
            ls_d = 1'b0;
          end
          else
          begin
            hs_d = 1'b0;
            ls_d = !sink_off_q || ls_source_limit;
          end
        end
        if (hs_d && (peak_trip || boot_uv))
        begin
          hs_d = 1'b0;
          ls_d = 1'b1;
        end
        if (output_overvoltage_guard || (ov_mask_q && !cycle_start))
        begin
          hs_d = 1'b0;
        end
        // sink limit turns low side off
        if (ls_sink_limit && !hs_d)
        begin
          sink_off_d = 1'b1;
        end
        if (sink_off_d)
        begin
          ls_d = 1'b0;
          hs_d = 1'b0;
        end
        if (!overload)
        begin
          cnt_d = HICCUP_CNT_RST;
        end
        else if (cycle_start)
        begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q >= ovl_lim)
          begin
            state_d = ST_OVL_HICCUP;
            cnt_d = HICCUP_CNT_RST;
            hs_d = 1'b0;
            ls_d = 1'b0;
          end
        end
      end
      ST_OVL_HICCUP:
      begin
        if (cycle_start)
        begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == ovl_hic_lim)
          begin
            state_d = ST_PREBIAS;
            cnt_d = HICCUP_CNT_RST;
          end
        end
      end
      ST_THERM_HOT:
      begin
        cnt_d = HICCUP_CNT_RST;
        if (thermal_cool)
        begin
          state_d = ST_THERM_COOL;
        end
      end
      ST_THERM_COOL:
      begin
        if (cycle_start)
        begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == th_lim)
          begin
            state_d = ST_IDLE;
            cnt_d = HICCUP_CNT_RST;
          end
        end
      end
    endcase
    if (state_q != ST_RUN)
    begin
      hs_d = 1'b0;
      ls_d = 1'b0;
    end
    if (thermal_hot && state_q != ST_THERM_HOT && state_q != ST_IDLE)
    begin
      state_d = ST_THERM_HOT;
      hs_d = 1'b0;
      ls_d = 1'b0;
      cnt_d = HICCUP_CNT_RST;
    end
    if (!enable_in || undervoltage_lockout)
    begin
      state_d = ST_IDLE;
      hs_d = 1'b0;
      ls_d = 1'b0;
      cnt_d = HICCUP_CNT_RST;
    end
    if (hs_d)
    begin
      ls_d = 1'b0;
    end
    hic_d = (state_d == ST_OVL_HICCUP) || (state_d == ST_THERM_HOT) || (state_d == ST_THERM_COOL);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= ST_IDLE;
      cnt_q <= HICCUP_CNT_RST;
      hs_q <= 1'b0;
      ls_q <= 1'b0;
      bc_q <= 1'b0;
      ssr_q <= 1'b1;
      hic_q <= 1'b0;
      ov_mask_q <= 1'b0;
      sink_off_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      hs_q <= hs_d;
      ls_q <= ls_d;
      bc_q <= bc_d;
      ssr_q <= ssr_d;
      hic_q <= hic_d;
      ov_mask_q <= ov_mask_d;
      sink_off_q <= sink_off_d;
    end
  end

  AST_NO_SHOOT: assert property (@(posedge clk) disable iff (!nrst) !(hs_q && ls_q))
    else $error("Both gates on.");
  AST_PREBIAS_OFF: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == ST_PREBIAS) |=> !hs_q && !ls_q)
    else $error("Gate on during prebias.");
  AST_OV_HS_OFF: assert property (@(posedge clk) disable iff (!nrst)
    output_overvoltage_guard |=> !hs_q)
    else $error("High side on in overvoltage.");
  AST_OV_NEXT_CYCLE: assert property (@(posedge clk) disable iff (!nrst)
    $rose(hs_q) |-> $past(cycle_start))
    else $error("High side started mid cycle.");
  AST_SRC_SKIP: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == ST_RUN && cycle_start && ls_source_limit) |=> !hs_q)
    else $error("High side not skipped.");
  AST_BOOT_UV: assert property (@(posedge clk) disable iff (!nrst)
    (boot_uv && hs_q) |=> !hs_q)
    else $error("High side stayed on in boot undervoltage.");
  AST_THERM_STOP: assert property (@(posedge clk) disable iff (!nrst)
    (thermal_hot && state_q == ST_RUN && enable_in && !undervoltage_lockout)
    |=> !hs_q && !ls_q && state_q == ST_THERM_HOT)
    else $error("Switching during over-temperature.");
  AST_DISABLE: assert property (@(posedge clk) disable iff (!nrst)
    (!enable_in || undervoltage_lockout) |=> state_q == ST_IDLE && !hs_q && !ls_q)
    else $error("Not idle while disabled.");
  AST_BOOT_CHARGE: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) |-> bc_q == ($past(boot_below_vin) && $past(boot_below_reg)))
    else $error("Bootstrap charge enabled wrongly.");
  COV_RUN_PULSE: cover property (@(posedge clk) disable iff (!nrst) state_q == ST_RUN ##1 $rose(hs_q));
  COV_OVL_HICCUP: cover property (@(posedge clk) disable iff (!nrst) $rose(state_q == ST_OVL_HICCUP));
  COV_THERM: cover property (@(posedge clk) disable iff (!nrst) $rose(state_q == ST_THERM_COOL));
endmodule // buck_switch_protection_control
